// ==== src/irq_ctl_pkg.sv ====
// Package with offsets, field positions, reset values and timing for the interrupt controller
package irq_ctl_pkg;

    // ****************************************
    // Sizes
    // ****************************************
    localparam int NUM_SRC = 19;
    localparam int IDX_W = 5;
    localparam int VEC_W = 16;
    localparam int ADDR_W = 8;

    // ****************************************
    // Register offsets (byte addresses)
    // ****************************************
    localparam logic [ADDR_W-1:0] MAIN_SOURCE_MASK_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] EXTENDED_MASK_ONE_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] EXTENDED_MASK_TWO_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] MAIN_LEVEL_SELECT_OFS = 8'h0c;
    localparam logic [ADDR_W-1:0] EXTENDED_LEVEL_ONE_OFS = 8'h10;
    localparam logic [ADDR_W-1:0] EXTENDED_LEVEL_TWO_OFS = 8'h14;
    localparam logic [ADDR_W-1:0] PENDING_FLAGS_OFS = 8'h18;
    localparam logic [ADDR_W-1:0] CONTROLLER_STATUS_OFS = 8'h1c;

    // ****************************************
    // Fields and reset values
    // ****************************************
    localparam int GATE_BIT = 7;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] LEVEL_RESET = 8'h00;
    localparam logic [7:0] MAIN_LEVEL_READ_TOP = 8'h80;
    localparam logic [NUM_SRC-1:0] PENDING_RESET = 19'h00000;
    localparam logic [IDX_W-1:0] RESERVED_IDX = 5'h11;
    localparam logic [NUM_SRC-1:0] USABLE_SRC = 19'h5ffff;
    localparam logic [NUM_SRC-1:0] HW_CLEAR_SRC = 19'h0000f;

    // ****************************************
    // Vectors and timing
    // ****************************************
    localparam logic [VEC_W-1:0] RESET_VECTOR = 16'h0000;
    localparam logic [VEC_W-1:0] VECTOR_BASE = 16'h0003;
    localparam int VECTOR_STEP_SHIFT = 3;
    localparam int CLK_PERIOD_NS = 40;
    localparam int DETECT_CYCLES = 1;
    localparam int LONG_CALL_CYCLES = 5;
    localparam logic [2:0] LONG_CALL_LAST = 3'(LONG_CALL_CYCLES - 1);

endpackage

// ==== src/irq_arbiter.sv ====
// Fixed-order two-level winner picker for the interrupt controller
`timescale 1ns/10ps
module irq_arbiter (
    input wire logic [irq_ctl_pkg::NUM_SRC-1:0] active, // Pending, enabled, gated sources
    input wire logic [irq_ctl_pkg::NUM_SRC-1:0] level_high, // Level select per source
    output logic any_active, // Some source requests
    output logic any_high, // Some high-level source requests
    output logic win_high, // Winner sits at high level
    output logic [irq_ctl_pkg::IDX_W-1:0] win_idx // Winner order index
);
    import irq_ctl_pkg::*;

    logic [NUM_SRC-1:0] act_hi;
    logic [NUM_SRC-1:0] act_lo;

    // Split requests by level, one slot per source
    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++) begin : split
            assign act_hi[g] = active[g] & level_high[g];
            assign act_lo[g] = active[g] & ~level_high[g];
        end
    endgenerate

    // High level first, then smallest order index
    always_comb begin
        any_active = |active;
        any_high = |act_hi;
        win_high = any_high;
        win_idx = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (any_high ? act_hi[i] : act_lo[i]) begin
                win_idx = IDX_W'(i);
            end
        end
    end

endmodule

// ==== src/irq_controller.sv ====
// Two-level vectored interrupt controller with APB register access
`timescale 1ns/10ps
module irq_controller (
    input wire logic pclk, // System clock, 25 MHz
    input wire logic presetn, // Asynchronous reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB write
    input wire logic [irq_ctl_pkg::ADDR_W-1:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic [irq_ctl_pkg::NUM_SRC-1:0] src_event, // Source valid-condition pulses
    input wire logic cpu_instr_end, // Pulse: an instruction other than return completes
    input wire logic cpu_next_multi, // Instruction after the ending one is multi-cycle
    input wire logic cpu_return_from_interrupt_end, // Pulse: return_from_interrupt completes
    input wire logic cpu_stall, // CPU stalled by memory write or buffer access
    output logic irq_request, // Registered request toward the CPU
    output logic call_busy, // Long call in progress
    output logic call_start, // Pulse: long call begins
    output logic [irq_ctl_pkg::VEC_W-1:0] call_vector, // Long call target address
    output logic [irq_ctl_pkg::IDX_W-1:0] call_index, // Order index being served
    output logic in_service_low, // Low-level service routine active
    output logic in_service_high // High-level service routine active
);
    import irq_ctl_pkg::*;

    // ****************************************
    // State
    // ****************************************
    typedef enum logic {PH_IDLE, PH_CALL} call_phase_type;

    typedef struct packed {
        logic [7:0] mask_main;
        logic [7:0] mask_ext1;
        logic [7:0] mask_ext2;
        logic [7:0] lvl_main;
        logic [7:0] lvl_ext1;
        logic [7:0] lvl_ext2;
        logic [NUM_SRC-1:0] pending;
        logic req;
        logic win_high;
        logic [IDX_W-1:0] win_idx;
        logic svc_low;
        logic svc_high;
        logic dis_recent;
        call_phase_type phase;
        logic [2:0] call_cnt;
        logic call_busy;
        logic call_start;
        logic [IDX_W-1:0] call_idx;
        logic [VEC_W-1:0] call_vec;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } ctl_state_type;

    localparam ctl_state_type STATE_RESET = '{
        mask_main: MASK_RESET,
        mask_ext1: MASK_RESET,
        mask_ext2: MASK_RESET,
        lvl_main: LEVEL_RESET,
        lvl_ext1: LEVEL_RESET,
        lvl_ext2: LEVEL_RESET,
        pending: PENDING_RESET,
        req: 1'b0,
        win_high: 1'b0,
        win_idx: '0,
        svc_low: 1'b0,
        svc_high: 1'b0,
        dis_recent: 1'b0,
        phase: PH_IDLE,
        call_cnt: '0,
        call_busy: 1'b0,
        call_start: 1'b0,
        call_idx: '0,
        call_vec: RESET_VECTOR,
        prdata: '0,
        pready: 1'b0,
        pslverr: 1'b0
    };

    ctl_state_type st_reg;
    ctl_state_type st_next;

    logic [NUM_SRC-1:0] enables;
    logic [NUM_SRC-1:0] levels;
    logic [NUM_SRC-1:0] active;
    logic any_active;
    logic any_high;
    logic arb_high;
    logic [IDX_W-1:0] arb_idx;
    logic take;
    logic level_ok;
    logic wr_en;
    logic setup;
    logic [31:0] rd_val;
    logic rd_hit;

    // ****************************************
    // Request gating and arbitration
    // ****************************************

    // Source n uses enable and level bit n of the joined registers
    assign enables = {st_reg.mask_ext2[3:0], st_reg.mask_ext1, st_reg.mask_main[6:0]};
    assign levels = {st_reg.lvl_ext2[3:0], st_reg.lvl_ext1, st_reg.lvl_main[6:0]};
    assign active = st_reg.pending & enables & USABLE_SRC & {NUM_SRC{st_reg.mask_main[GATE_BIT]}};

    irq_arbiter u_arbiter (
        .active(active),
        .level_high(levels),
        .any_active(any_active),
        .any_high(any_high),
        .win_high(arb_high),
        .win_idx(arb_idx)
    );

    // Only a level above the one in service may start a call
    assign level_ok = st_reg.win_high ? !st_reg.svc_high : !(st_reg.svc_low || st_reg.svc_high);

    // Call only at an instruction end, never at a return end or during a stall
    assign take = st_reg.req && cpu_instr_end && !cpu_return_from_interrupt_end && (st_reg.phase == PH_IDLE) && !cpu_stall
                  && level_ok && !(st_reg.dis_recent && cpu_next_multi);

    // ****************************************
    // APB decode
    // ****************************************
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pwrite && st_reg.pready && !st_reg.pslverr;

    // Read mux, unmapped addresses flagged
    always_comb begin
        rd_val = '0;
        rd_hit = 1'b1;
        case (paddr)
            MAIN_SOURCE_MASK_OFS: rd_val = {24'h000000, st_reg.mask_main};
            EXTENDED_MASK_ONE_OFS: rd_val = {24'h000000, st_reg.mask_ext1};
            EXTENDED_MASK_TWO_OFS: rd_val = {24'h000000, st_reg.mask_ext2};
            MAIN_LEVEL_SELECT_OFS: rd_val = {24'h000000, st_reg.lvl_main | MAIN_LEVEL_READ_TOP};
            EXTENDED_LEVEL_ONE_OFS: rd_val = {24'h000000, st_reg.lvl_ext1};
            EXTENDED_LEVEL_TWO_OFS: rd_val = {24'h000000, st_reg.lvl_ext2};
            PENDING_FLAGS_OFS: rd_val = {13'h0000, st_reg.pending};
            // Status word: winner index, winner level, request, busy, service levels
            CONTROLLER_STATUS_OFS: rd_val = {22'h000000, st_reg.svc_high, st_reg.svc_low, st_reg.call_busy,
                                             st_reg.req, st_reg.win_high, st_reg.win_idx};
            default: rd_hit = 1'b0;
        endcase
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        st_next = st_reg;
        st_next.call_start = 1'b0;

        // Bus answer: ready in the first access cycle
        st_next.pready = setup;
        st_next.pslverr = setup && !rd_hit;
        if (setup) begin
            st_next.prdata = pwrite ? 32'h00000000 : rd_val;
        end

        // Register writes
        if (wr_en) begin
            case (paddr)
                MAIN_SOURCE_MASK_OFS: st_next.mask_main = pwdata[7:0];
                EXTENDED_MASK_ONE_OFS: st_next.mask_ext1 = pwdata[7:0];
                EXTENDED_MASK_TWO_OFS: st_next.mask_ext2 = pwdata[7:0];
                MAIN_LEVEL_SELECT_OFS: st_next.lvl_main = {1'b0, pwdata[6:0]};
                EXTENDED_LEVEL_ONE_OFS: st_next.lvl_ext1 = pwdata[7:0];
                EXTENDED_LEVEL_TWO_OFS: st_next.lvl_ext2 = pwdata[7:0];
                PENDING_FLAGS_OFS: st_next.pending = pwdata[NUM_SRC-1:0] & USABLE_SRC;
                default: st_next.pending = st_reg.pending;
            endcase
        end

        // Note any enable being cleared until the next instruction end
        if (cpu_instr_end) begin
            st_next.dis_recent = 1'b0;
        end
        if (wr_en && (((paddr == MAIN_SOURCE_MASK_OFS) && |(st_reg.mask_main & ~pwdata[7:0]))
                      || ((paddr == EXTENDED_MASK_ONE_OFS) && |(st_reg.mask_ext1 & ~pwdata[7:0]))
                      || ((paddr == EXTENDED_MASK_TWO_OFS) && |(st_reg.mask_ext2 & ~pwdata[7:0])))) begin
            st_next.dis_recent = 1'b1;
        end

        // Detect: request and winner refreshed every clock
        st_next.req = any_active;
        st_next.win_high = arb_high;
        st_next.win_idx = arb_idx;

        // Long call sequencing
        case (st_reg.phase)
            PH_IDLE: begin
                if (take) begin
                    st_next.phase = PH_CALL;
                    st_next.call_cnt = LONG_CALL_LAST;
                    st_next.call_busy = 1'b1;
                    st_next.call_start = 1'b1;
                    st_next.call_idx = st_reg.win_idx;
                    st_next.call_vec = VEC_W'(VECTOR_BASE + (VEC_W'(st_reg.win_idx) << VECTOR_STEP_SHIFT));
                    if (st_reg.win_high) begin
                        st_next.svc_high = 1'b1;
                    end else begin
                        st_next.svc_low = 1'b1;
                    end
                    if (HW_CLEAR_SRC[st_reg.win_idx]) begin
                        st_next.pending[st_reg.win_idx] = 1'b0;
                    end
                end
            end
            PH_CALL: begin
                if (st_reg.call_cnt == 3'h0) begin
                    st_next.phase = PH_IDLE;
                    st_next.call_busy = 1'b0;
                end else begin
                    st_next.call_cnt = st_reg.call_cnt - 3'h1;
                end
            end
            default: begin
                st_next.phase = PH_IDLE;
                st_next.call_busy = 1'b0;
            end
        endcase

        // Return ends the highest level in service
        if (cpu_return_from_interrupt_end) begin
            if (st_reg.svc_high) begin
                st_next.svc_high = 1'b0;
            end else begin
                st_next.svc_low = 1'b0;
            end
        end

        // Hardware events set flags last so a set beats any clear
        st_next.pending = st_next.pending | (src_event & USABLE_SRC);
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= STATE_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign prdata = st_reg.prdata;
    assign pready = st_reg.pready;
    assign pslverr = st_reg.pslverr;
    assign irq_request = st_reg.req;
    assign call_busy = st_reg.call_busy;
    assign call_start = st_reg.call_start;
    assign call_vector = st_reg.call_vec;
    assign call_index = st_reg.call_idx;
    assign in_service_low = st_reg.svc_low;
    assign in_service_high = st_reg.svc_high;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Gate off means no request next cycle
    a_gate_blocks_req: assert property (!st_reg.mask_main[GATE_BIT] |=> !irq_request)
        else $error("request raised with global gate off");

    // Long call lasts exactly five cycles
    a_call_five_cycles: assert property ($rose(call_busy) |-> call_busy [*5] ##1 !call_busy)
        else $error("long call length is not five cycles");

    // Vector matches the served order index
    a_vector_spacing: assert property (call_busy |-> call_vector == VEC_W'(VECTOR_BASE + (VEC_W'(call_index) << 3)))
        else $error("vector does not match order index");

    // Sources 4 and up keep their flag through vectoring
    a_flag_kept_sw: assert property (take && (st_reg.win_idx > 5'h3) |=> st_reg.pending[$past(st_reg.win_idx)])
        else $error("software-cleared flag changed on vectoring");

    // No call while stalled or during a return
    a_stall_defers: assert property ((cpu_stall || cpu_return_from_interrupt_end) |-> !take)
        else $error("long call started during stall or return");

    // High service is never pre-empted
    a_high_no_preempt: assert property (in_service_high && !cpu_return_from_interrupt_end |=> !call_start)
        else $error("high-level routine pre-empted");

    // Software set of a flag raises a request when enabled
    a_sw_set_request: assert property (wr_en && (paddr == PENDING_FLAGS_OFS) && pwdata[0] && enables[0]
                                       && st_reg.mask_main[GATE_BIT] && (st_reg.pending[0] || 1'b1)
                                       ##1 (st_reg.pending[0] && enables[0] && st_reg.mask_main[GATE_BIT])
                                       |=> irq_request)
        else $error("software-set flag raised no request");

    // High-level request wins the arbitration
    a_high_wins: assert property (any_high |=> st_reg.win_high)
        else $error("low level won over high level");

    // Multi-cycle follower after an enable clear blocks the call
    a_disable_guard: assert property (st_reg.dis_recent && cpu_next_multi |-> !take)
        else $error("call taken after enable clear and multi-cycle instruction");

    c_call: cover property (call_start);
    c_preempt: cover property (in_service_low && call_start && st_reg.svc_high);
    c_reentry: cover property (cpu_return_from_interrupt_end && irq_request ##[1:30] call_start);
    c_guard: cover property (st_reg.dis_recent && cpu_next_multi && cpu_instr_end && st_reg.req);
    c_hw_clear: cover property (take && HW_CLEAR_SRC[st_reg.win_idx]);

endmodule

// ==== testbench/cpu_model.sv ====
// Behavioural CPU core model that ends instructions, returns and stalls
`timescale 1ns/10ps
module cpu_model (
    input wire logic pclk, // System clock
    input wire logic presetn, // Asynchronous reset, active low
    input wire logic run, // Execute instructions
    input wire logic return_from_interrupt_req, // Pulse: next instruction is a return
    input wire logic multi, // Next instruction is multi-cycle
    input wire logic stall_req, // Hold the CPU stalled
    input wire logic call_busy, // Long call in progress
    output logic cpu_instr_end, // Ordinary instruction completes
    output logic cpu_next_multi, // Following instruction is multi-cycle
    output logic cpu_return_from_interrupt_end, // Return completes
    output logic cpu_stall // CPU stalled
);
    logic return_from_interrupt_pend;
    // ****************************************
    // Instruction stream
    // ****************************************
    // One-cycle instructions; none while a long call runs or the core is stalled
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_instr_end <= 1'b0;
            cpu_next_multi <= 1'b0;
            cpu_return_from_interrupt_end <= 1'b0;
            cpu_stall <= 1'b0;
            return_from_interrupt_pend <= 1'b0;
        end else begin
            if (return_from_interrupt_req) begin
                return_from_interrupt_pend <= 1'b1;
            end
            cpu_stall <= stall_req;
            cpu_next_multi <= multi;
            cpu_instr_end <= 1'b0;
            cpu_return_from_interrupt_end <= 1'b0;
            if (run && !call_busy && !stall_req && !cpu_stall) begin
                if (return_from_interrupt_pend) begin
                    cpu_return_from_interrupt_end <= 1'b1;
                    return_from_interrupt_pend <= 1'b0;
                end else begin
                    cpu_instr_end <= 1'b1;
                end
            end
        end
    end
endmodule

// ==== testbench/tb_irq_controller.sv ====
// Self-checking bench for the two-level vectored interrupt controller
`timescale 1ns/10ps
module tb_irq_controller;
    import irq_ctl_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, irq_request, call_busy, call_start, in_service_low, in_service_high;
    logic [NUM_SRC-1:0] src_event = 19'h00000;
    logic cpu_instr_end, cpu_next_multi, cpu_return_from_interrupt_end, cpu_stall;
    logic [VEC_W-1:0] call_vector;
    logic [IDX_W-1:0] call_index;
    logic run = 1'b0;
    logic return_from_interrupt_req = 1'b0;
    logic multi = 1'b0;
    logic stall_req = 1'b0;
    int n_errors = 0;
    int n_checks = 0;
    int n_after = 0;

    always #(CLK_PERIOD_NS / 2) pclk = ~pclk;

    irq_controller uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .src_event(src_event), .cpu_instr_end(cpu_instr_end), .cpu_next_multi(cpu_next_multi),
        .cpu_return_from_interrupt_end(cpu_return_from_interrupt_end), .cpu_stall(cpu_stall), .irq_request(irq_request),
        .call_busy(call_busy), .call_start(call_start), .call_vector(call_vector),
        .call_index(call_index), .in_service_low(in_service_low), .in_service_high(in_service_high));

    cpu_model cpu (.pclk(pclk), .presetn(presetn), .run(run), .return_from_interrupt_req(return_from_interrupt_req), .multi(multi),
        .stall_req(stall_req), .call_busy(call_busy), .cpu_instr_end(cpu_instr_end),
        .cpu_next_multi(cpu_next_multi), .cpu_return_from_interrupt_end(cpu_return_from_interrupt_end), .cpu_stall(cpu_stall));

    // Instructions completed since the last return
    always @(posedge pclk) begin
        if (cpu_return_from_interrupt_end) begin
            n_after <= 0;
        end else if (cpu_instr_end) begin
            n_after <= n_after + 1;
        end
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One APB transfer, entered just after a rising edge
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int t;
        t = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            t++;
        end while (pready !== 1'b1 && t < 50);
        chk("pready", {31'h0, pready}, 32'h1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd_chk(input string name, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(name, r, exp);
    endtask

    // Enables, levels and global gate for all sources
    task automatic cfg(input logic [18:0] en, input logic [18:0] hi, input logic gate);
        wr(MAIN_SOURCE_MASK_OFS, {24'h0, gate, en[6:0]});
        wr(EXTENDED_MASK_ONE_OFS, {24'h0, en[14:7]});
        wr(EXTENDED_MASK_TWO_OFS, {28'h0, en[18:15]});
        wr(MAIN_LEVEL_SELECT_OFS, {25'h0, hi[6:0]});
        wr(EXTENDED_LEVEL_ONE_OFS, {24'h0, hi[14:7]});
        wr(EXTENDED_LEVEL_TWO_OFS, {28'h0, hi[18:15]});
    endtask

    // Wait for a long call and check what it serves
    task automatic take(input logic [IDX_W-1:0] idx, input logic hi_s, input logic lo_s);
        int t;
        t = 0;
        do begin
            @(posedge pclk);
            t++;
        end while (call_start !== 1'b1 && t < 200);
        chk("call_start", {31'h0, call_start}, 32'h1);
        chk("call_index", {27'h0, call_index}, {27'h0, idx});
        chk("call_vector", {16'h0, call_vector}, {16'h0, VECTOR_BASE + (16'(idx) << VECTOR_STEP_SHIFT)});
        chk("in_service_high", {31'h0, in_service_high}, {31'h0, hi_s});
        chk("in_service_low", {31'h0, in_service_low}, {31'h0, lo_s});
    endtask

    task automatic no_call(input int n);
        int c;
        c = 0;
        repeat (n) begin
            @(posedge pclk);
            if (call_start === 1'b1) c++;
        end
        chk("call_count", c, 0);
    endtask

    // Return from the service routine, then let the design take it
    task automatic do_return_from_interrupt;
        int t;
        t = 0;
        return_from_interrupt_req <= 1'b1;
        @(posedge pclk);
        return_from_interrupt_req <= 1'b0;
        do begin
            @(posedge pclk);
            t++;
        end while (cpu_return_from_interrupt_end !== 1'b1 && t < 100);
        @(posedge pclk);
    endtask

    task automatic end_of_test;
        if (n_errors == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        logic [31:0] r;
        logic e;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        run <= 1'b1;
        @(posedge pclk);
        rd_chk("main_mask", MAIN_SOURCE_MASK_OFS, 32'h0);
        rd_chk("ext_mask_two", EXTENDED_MASK_TWO_OFS, 32'h0);
        rd_chk("main_level", MAIN_LEVEL_SELECT_OFS, {24'h0, MAIN_LEVEL_READ_TOP});
        rd_chk("ext_level_one", EXTENDED_LEVEL_ONE_OFS, 32'h0);
        rd_chk("pending", PENDING_FLAGS_OFS, 32'h0);
        apb(1'b0, 8'h20, 32'h0, r, e);
        chk("pslverr", {31'h0, e}, 32'h1);
        // Flag set while gate is off, then stall defers the call
        cfg(19'h00010, 19'h0, 1'b0);
        src_event[4] <= 1'b1;
        @(posedge pclk);
        src_event[4] <= 1'b0;
        rd_chk("pending", PENDING_FLAGS_OFS, 32'h10);
        no_call(10);
        chk("irq_request", {31'h0, irq_request}, 32'h0);
        stall_req <= 1'b1;
        wr(MAIN_SOURCE_MASK_OFS, 32'h90);
        no_call(12);
        chk("irq_request", {31'h0, irq_request}, 32'h1);
        stall_req <= 1'b0;
        take(5'h04, 1'b0, 1'b1);
        rd_chk("pending_kept", PENDING_FLAGS_OFS, 32'h10);
        wr(PENDING_FLAGS_OFS, 32'h0);
        do_return_from_interrupt();
        // Fastest response: detect, then five call cycles
        src_event[4] <= 1'b1;
        @(posedge pclk);
        src_event[4] <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("call_early", {31'h0, call_start}, 32'h0);
        @(posedge pclk);
        chk("call_start", {31'h0, call_start}, 32'h1);
        repeat (LONG_CALL_CYCLES) begin
            chk("call_busy", {31'h0, call_busy}, 32'h1);
            @(posedge pclk);
        end
        chk("call_busy_end", {31'h0, call_busy}, 32'h0);
        wr(PENDING_FLAGS_OFS, 32'h0);
        do_return_from_interrupt();
        // Every usable source by software flag
        for (int i = 0; i < NUM_SRC; i++) begin
            if (i == int'(RESERVED_IDX)) continue;
            cfg(19'(1) << i, 19'h0, 1'b1);
            wr(PENDING_FLAGS_OFS, 32'(1) << i);
            take(5'(i), 1'b0, 1'b1);
            rd_chk("pending_after", PENDING_FLAGS_OFS, (i < 4) ? 32'h0 : 32'(1) << i);
            wr(PENDING_FLAGS_OFS, 32'h0);
            do_return_from_interrupt();
        end
        // Arbitration, pre-emption and re-entry
        cfg(19'h00026, 19'h00020, 1'b0);
        wr(PENDING_FLAGS_OFS, 32'h06);
        wr(MAIN_SOURCE_MASK_OFS, 32'ha6);
        take(5'h01, 1'b0, 1'b1);
        wr(PENDING_FLAGS_OFS, 32'h24);
        take(5'h05, 1'b1, 1'b1);
        no_call(30);
        do_return_from_interrupt();
        take(5'h05, 1'b1, 1'b1);
        chk("instr_after_return_from_interrupt", n_after, 1);
        wr(PENDING_FLAGS_OFS, 32'h04);
        do_return_from_interrupt();
        chk("in_service_high", {31'h0, in_service_high}, 32'h0);
        no_call(20);
        do_return_from_interrupt();
        take(5'h02, 1'b0, 1'b1);
        chk("instr_after_return_from_interrupt", n_after, 1);
        wr(PENDING_FLAGS_OFS, 32'h0);
        do_return_from_interrupt();
        // Gate cleared while a request stands, multi-cycle instruction next
        run <= 1'b0;
        multi <= 1'b1;
        cfg(19'h00010, 19'h0, 1'b1);
        wr(PENDING_FLAGS_OFS, 32'h10);
        @(posedge pclk);
        chk("irq_request", {31'h0, irq_request}, 32'h1);
        fork
            wr(MAIN_SOURCE_MASK_OFS, 32'h10);
            begin
                @(posedge pclk);
                run <= 1'b1;
            end
        join
        no_call(10);
        chk("irq_request", {31'h0, irq_request}, 32'h0);
        multi <= 1'b0;
        wr(PENDING_FLAGS_OFS, 32'h0);
        end_of_test();
    end

    // Watchdog
    initial begin
        #(CLK_PERIOD_NS * 20000);
        n_errors++;
        end_of_test();
    end
endmodule
